/* logic/eif_defines.vh */
// register map, field positions and reset values of the external interrupt flag block
`ifndef EIF_DEFINES_VH
`define EIF_DEFINES_VH

// byte offsets of the registers
`define EIF_OFF_CTRL 8'h00
`define EIF_OFF_PINCFG 8'h04
`define EIF_OFF_IRQ_STAT 8'h08
`define EIF_OFF_IRQ_MASK 8'h0C
`define EIF_OFF_PIN_LEVEL 8'h10

// control register fields
`define EIF_CTRL_TYPE0 0
`define EIF_CTRL_FLAG0 1
`define EIF_CTRL_TYPE1 2
`define EIF_CTRL_FLAG1 3
`define EIF_CTRL_W 4

// pin configuration fields, 1 = active high
`define EIF_PINCFG_POL0 0
`define EIF_PINCFG_POL1 1

// event, mask and pin level fields share one layout
`define EIF_EV_EXT0 0
`define EIF_EV_EXT1 1
`define EIF_EV_W 2

// reset values
`define EIF_TYPE_RST 1'h0
`define EIF_POL_RST 1'h0
`define EIF_STAT_RST 2'h0
`define EIF_MASK_RST 2'h0
// pin level that reads inactive under the reset polarity
`define EIF_PIN_IDLE 1'h1

// type select encodings
`define EIF_TYPE_LEVEL 1'h0
`define EIF_TYPE_EDGE 1'h1

// bus responses
`define EIF_RESP_OKAY 2'h0
`define EIF_RESP_SLVERR 2'h2

`endif

/* logic/eif_detect.v */
// synchroniser, trigger detection and pending flag of one external interrupt input
`timescale 1ns/1ps
`include "eif_defines.vh"

module eif_detect
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // pin
  input wire pin_in,
  // configuration
  input wire polarity,
  input wire type_select,
  // clears
  input wire sw_clear,
  input wire vector_ack,
  // results
  output reg pending_flag_q,
  output wire flag_event,
  output wire pin_level
);

  reg sync1_q;
  reg sync2_q;
  reg active_prev_q;
  wire active;
  reg pending_flag_d;

  // two stages before anything looks at the pin
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // idle level, so reset itself never looks like an edge
      sync1_q <= `EIF_PIN_IDLE;
      sync2_q <= `EIF_PIN_IDLE;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // polarity applied after sync; changing it while the pin rests can fake an edge
  assign active = polarity ? sync2_q : ~sync2_q;
  assign pin_level = sync2_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
      active_prev_q <= 1'h0;
    else
      active_prev_q <= active;
  end

  // one cycle per qualifying transition, also used as the sticky event source
  assign flag_event = active & ~active_prev_q;

  always @*
  begin
    pending_flag_d = pending_flag_q;
    if (type_select == `EIF_TYPE_EDGE)
    begin
      if (flag_event)
        pending_flag_d = 1'h1;
      else if (sw_clear || vector_ack)
        pending_flag_d = 1'h0;
    end
    else
    begin
      // level mode: flag simply mirrors the active level
      pending_flag_d = active;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      pending_flag_q <= 1'h0;
    else
      pending_flag_q <= pending_flag_d;
  end

endmodule

/* logic/eif_top.v */
// external interrupt flag block with AXI4-Lite register slave and interrupt output
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "eif_defines.vh"

module eif_top
#(
  parameter ADDR_W = 8
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // external interrupt pins
  input wire ext_irq_in0,
  input wire ext_irq_in1,
  // core vectoring side
  input wire vector_ack0,
  input wire vector_ack1,
  output wire ext0_pending_flag,
  output wire ext1_pending_flag,
  // interrupt
  output wire irq
);

  // register address decode, shared by read and write paths
  function is_mapped;
    input [ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `EIF_OFF_CTRL) ||
                  (addr == `EIF_OFF_PINCFG) ||
                  (addr == `EIF_OFF_IRQ_STAT) ||
                  (addr == `EIF_OFF_IRQ_MASK) ||
                  (addr == `EIF_OFF_PIN_LEVEL);
    end
  endfunction

  // write path state
  reg aw_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg w_hold_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire do_write;
  wire lane0;
  wire wr_ctrl;
  wire wr_pincfg;
  wire wr_stat;
  wire wr_mask;

  // configuration and interrupt registers
  reg ext0_type_select_q;
  reg ext1_type_select_q;
  reg ext0_polarity_q;
  reg ext1_polarity_q;
  reg [`EIF_EV_W-1:0] irq_stat_q;
  reg [`EIF_EV_W-1:0] irq_stat_d;
  reg [`EIF_EV_W-1:0] irq_mask_q;

  // detector results
  wire ext0_flag;
  wire ext1_flag;
  wire ext0_event;
  wire ext1_event;
  wire ext0_level;
  wire ext1_level;
  wire sw_clear0;
  wire sw_clear1;
  wire [`EIF_EV_W-1:0] events;
  wire [`EIF_EV_W-1:0] w1c_bits;

  // read path
  wire rd_take;
  reg [31:0] rd_value;
  reg rd_ok;

  // ---------------- write channel ----------------
  // address and data are captured independently, in either order
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready = ~w_hold_q;
  assign do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'h0;
      awaddr_q <= {ADDR_W{1'b0}};
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_q <= 1'h1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_hold_q <= 1'h0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold_q <= 1'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_q <= 1'h1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_hold_q <= 1'h0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= `EIF_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'h1;
      s_axi_bresp <= is_mapped(awaddr_q) ? `EIF_RESP_OKAY : `EIF_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'h0;
    end
  end

  // every field lives in byte lane 0; other lanes are ignored
  assign lane0 = wstrb_q[0];
  assign wr_ctrl = do_write & lane0 & (awaddr_q == `EIF_OFF_CTRL);
  assign wr_pincfg = do_write & lane0 & (awaddr_q == `EIF_OFF_PINCFG);
  assign wr_stat = do_write & lane0 & (awaddr_q == `EIF_OFF_IRQ_STAT);
  assign wr_mask = do_write & lane0 & (awaddr_q == `EIF_OFF_IRQ_MASK);

  // ---------------- configuration registers ----------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext0_type_select_q <= `EIF_TYPE_RST;
      ext1_type_select_q <= `EIF_TYPE_RST;
    end
    else if (wr_ctrl)
    begin
      ext0_type_select_q <= wdata_q[`EIF_CTRL_TYPE0];
      ext1_type_select_q <= wdata_q[`EIF_CTRL_TYPE1];
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext0_polarity_q <= `EIF_POL_RST;
      ext1_polarity_q <= `EIF_POL_RST;
    end
    else if (wr_pincfg)
    begin
      ext0_polarity_q <= wdata_q[`EIF_PINCFG_POL0];
      ext1_polarity_q <= wdata_q[`EIF_PINCFG_POL1];
    end
  end

  // writing 0 to a flag bit clears it in edge mode only; writing 1 leaves it alone
  assign sw_clear0 = wr_ctrl & ~wdata_q[`EIF_CTRL_FLAG0];
  assign sw_clear1 = wr_ctrl & ~wdata_q[`EIF_CTRL_FLAG1];

  // ---------------- detectors ----------------
  eif_detect u_ext0
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ext_irq_in0),
    .polarity(ext0_polarity_q),
    .type_select(ext0_type_select_q),
    .sw_clear(sw_clear0),
    .vector_ack(vector_ack0),
    .pending_flag_q(ext0_flag),
    .flag_event(ext0_event),
    .pin_level(ext0_level)
  );

  eif_detect u_ext1
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(ext_irq_in1),
    .polarity(ext1_polarity_q),
    .type_select(ext1_type_select_q),
    .sw_clear(sw_clear1),
    .vector_ack(vector_ack1),
    .pending_flag_q(ext1_flag),
    .flag_event(ext1_event),
    .pin_level(ext1_level)
  );

  assign ext0_pending_flag = ext0_flag;
  assign ext1_pending_flag = ext1_flag;

  // ---------------- sticky status and mask ----------------
  assign events = {ext1_event, ext0_event};
  assign w1c_bits = wr_stat ? wdata_q[`EIF_EV_W-1:0] : {`EIF_EV_W{1'b0}};

  // a new event in the clearing cycle survives the clear
  always @*
  begin
    irq_stat_d = (irq_stat_q & ~w1c_bits) | events;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= `EIF_STAT_RST;
    else
      irq_stat_q <= irq_stat_d;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_q <= `EIF_MASK_RST;
    else if (wr_mask)
      irq_mask_q <= wdata_q[`EIF_EV_W-1:0];
  end

  // built from registers only, so it cannot glitch
  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------- read channel ----------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  always @*
  begin
    rd_value = 32'h00000000;
    rd_ok = 1'h1;
    case (s_axi_araddr)
      `EIF_OFF_CTRL:
      begin
        rd_value[`EIF_CTRL_TYPE0] = ext0_type_select_q;
        rd_value[`EIF_CTRL_FLAG0] = ext0_flag;
        rd_value[`EIF_CTRL_TYPE1] = ext1_type_select_q;
        rd_value[`EIF_CTRL_FLAG1] = ext1_flag;
      end
      `EIF_OFF_PINCFG:
      begin
        rd_value[`EIF_PINCFG_POL0] = ext0_polarity_q;
        rd_value[`EIF_PINCFG_POL1] = ext1_polarity_q;
      end
      `EIF_OFF_IRQ_STAT:
      begin
        rd_value[`EIF_EV_W-1:0] = irq_stat_q;
      end
      `EIF_OFF_IRQ_MASK:
      begin
        rd_value[`EIF_EV_W-1:0] = irq_mask_q;
      end
      `EIF_OFF_PIN_LEVEL:
      begin
        rd_value[`EIF_EV_EXT0] = ext0_level;
        rd_value[`EIF_EV_EXT1] = ext1_level;
      end
      default:
      begin
        rd_ok = is_mapped(s_axi_araddr);
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `EIF_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'h1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? `EIF_RESP_OKAY : `EIF_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'h0;
    end
  end

  // prot signals carry no meaning for this block
  wire unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // upper lanes and bits are accepted and dropped
  wire unused_wr;
  assign unused_wr = ^{wstrb_q[3:1], wdata_q[31:`EIF_CTRL_W]};

endmodule

/* sim/eif_chk.sv */
// assertion checker for the external interrupt flag block
`timescale 1ns/1ps
`include "eif_defines.vh"
module eif_chk
#(
  parameter ADDR_W = 8
)
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // pins and vectoring
  input wire ext_irq_in0,
  input wire ext_irq_in1,
  input wire vector_ack0,
  input wire vector_ack1,
  input wire ext0_pending_flag,
  input wire ext1_pending_flag
);
  // shadow of type and polarity, only from writes whose address and data handshake in the same cycle
  reg [1:0] type_q;
  reg [1:0] pol_q;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      type_q <= 2'h0;
      pol_q <= 2'h0;
    end
    else if (wr_go && s_axi_awaddr == `EIF_OFF_CTRL)
      type_q <= {s_axi_wdata[`EIF_CTRL_TYPE1], s_axi_wdata[`EIF_CTRL_TYPE0]};
    else if (wr_go && s_axi_awaddr == `EIF_OFF_PINCFG)
      pol_q <= s_axi_wdata[1:0];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  e0_ack_a: assert property (type_q[0] && vector_ack0 |=> !ext0_pending_flag)
    else $error("edge flag zero kept after vectoring");
  e1_ack_a: assert property (type_q[1] && vector_ack1 |=> !ext1_pending_flag)
    else $error("edge flag one kept after vectoring");
  // eight quiet cycles cover the synchroniser lag and the reset flush
  l0_follow_a: assert property (
    (!type_q[0] && $stable(pol_q) && $stable(ext_irq_in0)) [*8]
    |-> ext0_pending_flag == (pol_q[0] ~^ ext_irq_in0))
    else $error("level flag zero wrong");
  l1_follow_a: assert property (
    (!type_q[1] && $stable(pol_q) && $stable(ext_irq_in1)) [*8]
    |-> ext1_pending_flag == (pol_q[1] ~^ ext_irq_in1))
    else $error("level flag one wrong");
endmodule
bind eif_top eif_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

/* sim/eif_core_model.sv */
// core vectoring model: acknowledges a pending flag after a delay
`timescale 1ns/1ps
module eif_core_model
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // flags and bench control
  input wire [1:0] flag,
  input wire [1:0] ack_en,
  input wire [3:0] ack_delay,
  // vectoring
  output reg [1:0] vector_ack
);
  reg [3:0] wait_q [0:1];
  integer i;
  always @(posedge aclk)
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      // a level flag stays up, so the core keeps vectoring like a real one
      if (!aresetn || !ack_en[i] || !flag[i] || vector_ack[i])
      begin
        wait_q[i] <= 4'h0;
        vector_ack[i] <= 1'h0;
      end
      else if (wait_q[i] == ack_delay)
        vector_ack[i] <= 1'h1;
      else
      begin
        wait_q[i] <= wait_q[i] + 4'h1;
        vector_ack[i] <= 1'h0;
      end
    end
  end
endmodule

/* sim/eif_top_tb.sv */
// self-checking bench for the external interrupt flag block
`timescale 1ns/1ps
`include "eif_defines.vh"
module eif_top_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_irq_in0 = 1'h1, ext_irq_in1 = 1'h1;
  logic ext0_pending_flag, ext1_pending_flag, irq;
  wire vector_ack0, vector_ack1;
  logic [1:0] ack_en = 2'h0;
  logic [3:0] ack_delay = 4'h0;
  integer seed = 32'h8d15047a;
  int num_errors = 0, n_tests = 0, k, t, p, ch, m_type, m_mask, m_stat;
  int m_flag [2];
  eif_top i_dut (.*);
  eif_core_model i_core (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
    .flag({ext1_pending_flag, ext0_pending_flag}), .ack_delay(ack_delay),
    .vector_ack({vector_ack1, vector_ack0}));
  always #10 aclk = ~aclk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        num_errors++;
        $display("wrong value %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic done, aw_t, w_t;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      done = 1'h0;
      while (!done)
      begin
        @(negedge aclk);
        aw_t = s_axi_awvalid & s_axi_awready;
        w_t = s_axi_wvalid & s_axi_wready;
        done = s_axi_bvalid;
        if (done)
          chk("bresp", r, s_axi_bresp);
        @(posedge aclk);
        if (aw_t)
          s_axi_awvalid <= 1'h0;
        if (w_t)
          s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic done, ar_t;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      done = 1'h0;
      while (!done)
      begin
        @(negedge aclk);
        ar_t = s_axi_arvalid & s_axi_arready;
        done = s_axi_rvalid;
        if (done)
        begin
          chk("rdata", e, s_axi_rdata);
          chk("rresp", r, s_axi_rresp);
        end
        @(posedge aclk);
        if (ar_t)
          s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      @(posedge aclk);
    end
  endtask
  // flags and irq sampled mid-cycle, then the control and status registers read back
  task check_all;
    begin
      @(negedge aclk);
      chk("flag0", m_flag[0], ext0_pending_flag);
      chk("flag1", m_flag[1], ext1_pending_flag);
      chk("irq", (m_stat & m_mask) != 0, irq);
      @(posedge aclk);
      axi_rd(`EIF_OFF_CTRL, m_flag[1] * 8 + m_type * 5 + m_flag[0] * 2, `EIF_RESP_OKAY);
      axi_rd(`EIF_OFF_IRQ_STAT, m_stat, `EIF_RESP_OKAY);
    end
  endtask
  task set_pin(input int c, input int v);
    if (c == 1)
      ext_irq_in1 <= v[0];
    else
      ext_irq_in0 <= v[0];
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("watchdog expired");
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    // reset itself must log no event
    for (k = 0; k < 6; k++)
      axi_rd(k * 4, (k == 4) * 3, (k == 5) ? `EIF_RESP_SLVERR : `EIF_RESP_OKAY);
    axi_wr(8'h14, 32'hF, `EIF_RESP_SLVERR);
    for (k = 0; k < 8; k++)
    begin
      t = k % 2;
      p = k / 2 % 2;
      ch = k / 4;
      axi_wr(`EIF_OFF_PINCFG, p * 3, `EIF_RESP_OKAY);
      // polarity change may fake an edge, so park the pins and flush
      ext_irq_in0 <= !p;
      ext_irq_in1 <= !p;
      ack_en <= 2'h0;
      repeat (6) @(posedge aclk);
      m_type = t;
      axi_wr(`EIF_OFF_CTRL, t * 5, `EIF_RESP_OKAY);
      axi_wr(`EIF_OFF_IRQ_STAT, 3, `EIF_RESP_OKAY);
      m_mask = $random(seed) & 3;
      axi_wr(`EIF_OFF_IRQ_MASK, m_mask, `EIF_RESP_OKAY);
      m_stat = 0;
      m_flag[0] = 0;
      m_flag[1] = 0;
      ack_delay <= $random(seed) & 7;
      ack_en <= t ? 2'h0 : 2'h1 << ch;
      check_all;
      set_pin(ch, p);
      repeat (6 + ($random(seed) & 3)) @(posedge aclk);
      m_flag[ch] = 1;
      m_stat = 1 << ch;
      check_all;
      set_pin(ch, !p);
      repeat (6) @(posedge aclk);
      m_flag[ch] = t;
      check_all;
      if (t)
      begin
        if ($random(seed) & 1)
          ack_en <= 2'h1 << ch;
        else
          axi_wr(`EIF_OFF_CTRL, 5, `EIF_RESP_OKAY);
        repeat (12) @(posedge aclk);
        m_flag[ch] = 0;
        check_all;
      end
      axi_wr(`EIF_OFF_IRQ_STAT, m_stat, `EIF_RESP_OKAY);
      m_stat = 0;
      check_all;
    end
    stop_test;
  end
endmodule
